// ### msb_regs.vh
// msb_regs.vh: register offsets, flag field positions, reset codes and timing counts
// assumes inclusion by the monitor status bank; definitions only
`ifndef MSB_REGS_VH
`define MSB_REGS_VH

// 7-bit port addresses
`define MSB_ADDR_SENS_A_OFS   7'h08
`define MSB_ADDR_CONV_A_OFS   7'h09
`define MSB_ADDR_CONV_A_GAIN  7'h0A
`define MSB_ADDR_MIN_CORE     7'h25
`define MSB_ADDR_MIN_AUX      7'h26
`define MSB_ADDR_MIN_BRAM     7'h27
`define MSB_ADDR_MAX_PS_CORE  7'h28
`define MSB_ADDR_MAX_PS_AUX   7'h29
`define MSB_ADDR_MAX_PS_MEMIO 7'h2A
`define MSB_ADDR_UNASSIGNED_A 7'h2B
`define MSB_ADDR_MIN_PS_CORE  7'h2C
`define MSB_ADDR_MIN_PS_AUX   7'h2D
`define MSB_ADDR_MIN_PS_MEMIO 7'h2E
`define MSB_ADDR_UNASSIGNED_B 7'h2F
`define MSB_ADDR_SENS_B_OFS   7'h30
`define MSB_ADDR_CONV_B_OFS   7'h31
`define MSB_ADDR_CONV_B_GAIN  7'h32
`define MSB_ADDR_UNUSED_LO    7'h33
`define MSB_ADDR_UNUSED_HI    7'h3E
`define MSB_ADDR_FLAG         7'h3F

// flag register fields
`define MSB_FLAG_ALARM_LSB    0
`define MSB_FLAG_OT_BIT       3
`define MSB_FLAG_REF_BIT      9
`define MSB_FLAG_JTGRO_BIT    10
`define MSB_FLAG_JTGBL_BIT    11

// channel numbers carried by the measurement strobe and, for calibration, the conversion-start strobe
`define MSB_CH_CAL            5'h08
`define MSB_CH_CORE           5'h01
`define MSB_CH_AUX            5'h02
`define MSB_CH_BRAM           5'h06
`define MSB_CH_PS_CORE        5'h0D
`define MSB_CH_PS_AUX         5'h0E
`define MSB_CH_PS_MEMIO       5'h0F

// reset codes for extreme trackers and the read value of undefined locations
`define MSB_MIN_RESET         16'hFFFF
`define MSB_MAX_RESET         16'h0000
`define MSB_UNDEF_VALUE       16'h0000

// calibration timing
`define MSB_CONV_CYCLES       10'd26
`define MSB_CAL_FACTOR        3'd4
`define MSB_CAL_CYCLES        (`MSB_CONV_CYCLES * `MSB_CAL_FACTOR)

// gain coefficient fields
`define MSB_GAIN_SIGN_BIT     6
`define MSB_GAIN_MAG_MAX      6'h3F

`endif

// ### msb_status_bank.v
// msb_status_bank.v: read-only status bank of a dual converter supply monitor
// assumes measurement strobes and calibration results come from same-clock logic
`timescale 1ns/1ps
`include "msb_regs.vh"

module msb_status_bank (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clk_en,
  input  wire        rcp_en,
  input  wire        rcp_we,
  input  wire [6:0]  rcp_addr,
  input  wire [15:0] rcp_di,
  output reg  [15:0] rcp_do,
  output reg         rcp_rdy,
  input  wire        meas_valid,
  input  wire [4:0]  meas_channel,
  input  wire [15:0] meas_data,
  input  wire        conv_start,
  input  wire [4:0]  conv_channel,
  input  wire [11:0] sens_a_offset_meas,
  input  wire [11:0] conv_a_offset_meas,
  input  wire [6:0]  conv_a_gain_meas,
  input  wire [11:0] sens_b_offset_meas,
  input  wire [11:0] conv_b_offset_meas,
  input  wire [6:0]  conv_b_gain_meas,
  input  wire [6:0]  alarm_flags,
  input  wire        over_temp_flag,
  input  wire        internal_ref_sel,
  input  wire        jtag_readonly_flag,
  input  wire        jtag_blocked_flag,
  output reg         busy,
  output reg         cal_done
);

  // offset negation, 12-bit msb justified
  function [15:0] ofs_coef;
    input [11:0] meas;
    begin
      ofs_coef = {12'h000 - meas, 4'h0};
    end
  endfunction

  // gain: sign set for positive correction, magnitude clamped
  function [15:0] gain_coef;
    input [6:0] err;
    reg   [5:0] mag;
    begin
      mag = err[5:0];
      if (mag > `MSB_GAIN_MAG_MAX)
        mag = `MSB_GAIN_MAG_MAX;
      gain_coef = {9'h000, ~err[`MSB_GAIN_SIGN_BIT], mag};
    end
  endfunction

  reg [15:0] min_core_supply_reg;
  reg [15:0] min_aux_supply_reg;
  reg [15:0] min_blockram_supply_reg;
  reg [15:0] max_ps_core_supply_reg;
  reg [15:0] max_ps_aux_supply_reg;
  reg [15:0] max_ps_memio_supply_reg;
  reg [15:0] min_ps_core_supply_reg;
  reg [15:0] min_ps_aux_supply_reg;
  reg [15:0] min_ps_memio_supply_reg;
  reg [15:0] conv_a_sensor_offset_coef_reg;
  reg [15:0] conv_a_offset_coef_reg;
  reg [15:0] conv_a_gain_coef_reg;
  reg [15:0] conv_b_sensor_offset_coef_reg;
  reg [15:0] conv_b_offset_coef_reg;
  reg [15:0] conv_b_gain_coef_reg;
  reg [15:0] flag_status_reg;
  reg [9:0]  cal_cnt_reg;
  reg [15:0] rd_next;

  // extremes, tracked on full 16-bit results
  always @(posedge core_clk) begin
    if (rst) begin
      min_core_supply_reg     <= `MSB_MIN_RESET;
      min_aux_supply_reg      <= `MSB_MIN_RESET;
      min_blockram_supply_reg <= `MSB_MIN_RESET;
      min_ps_core_supply_reg  <= `MSB_MIN_RESET;
      min_ps_aux_supply_reg   <= `MSB_MIN_RESET;
      min_ps_memio_supply_reg <= `MSB_MIN_RESET;
      max_ps_core_supply_reg  <= `MSB_MAX_RESET;
      max_ps_aux_supply_reg   <= `MSB_MAX_RESET;
      max_ps_memio_supply_reg <= `MSB_MAX_RESET;
    end else if (clk_en && meas_valid) begin
      case (meas_channel)
        `MSB_CH_CORE: begin
          if (meas_data < min_core_supply_reg)
            min_core_supply_reg <= meas_data;
        end
        `MSB_CH_AUX: begin
          if (meas_data < min_aux_supply_reg)
            min_aux_supply_reg <= meas_data;
        end
        `MSB_CH_BRAM: begin
          if (meas_data < min_blockram_supply_reg)
            min_blockram_supply_reg <= meas_data;
        end
        `MSB_CH_PS_CORE: begin
          if (meas_data < min_ps_core_supply_reg)
            min_ps_core_supply_reg <= meas_data;
          if (meas_data > max_ps_core_supply_reg)
            max_ps_core_supply_reg <= meas_data;
        end
        `MSB_CH_PS_AUX: begin
          if (meas_data < min_ps_aux_supply_reg)
            min_ps_aux_supply_reg <= meas_data;
          if (meas_data > max_ps_aux_supply_reg)
            max_ps_aux_supply_reg <= meas_data;
        end
        `MSB_CH_PS_MEMIO: begin
          if (meas_data < min_ps_memio_supply_reg)
            min_ps_memio_supply_reg <= meas_data;
          if (meas_data > max_ps_memio_supply_reg)
            max_ps_memio_supply_reg <= meas_data;
        end
        default: begin
        end
      endcase
    end
  end

  // self-calibration sequence and coefficient capture
  always @(posedge core_clk) begin
    if (rst) begin
      busy                          <= 1'b0;
      cal_done                      <= 1'b0;
      cal_cnt_reg                   <= 10'd0;
      conv_a_sensor_offset_coef_reg <= 16'h0000;
      conv_a_offset_coef_reg        <= 16'h0000;
      conv_a_gain_coef_reg          <= 16'h0000;
      conv_b_sensor_offset_coef_reg <= 16'h0000;
      conv_b_offset_coef_reg        <= 16'h0000;
      conv_b_gain_coef_reg          <= 16'h0000;
    end else if (clk_en) begin
      cal_done <= 1'b0;
      if (busy) begin
        if (cal_cnt_reg == `MSB_CAL_CYCLES - 10'd1) begin
          busy                          <= 1'b0;
          cal_done                      <= 1'b1;
          cal_cnt_reg                   <= 10'd0;
          conv_a_sensor_offset_coef_reg <= ofs_coef(sens_a_offset_meas);
          conv_a_offset_coef_reg        <= ofs_coef(conv_a_offset_meas);
          conv_a_gain_coef_reg          <= gain_coef(conv_a_gain_meas);
          conv_b_sensor_offset_coef_reg <= ofs_coef(sens_b_offset_meas);
          conv_b_offset_coef_reg        <= ofs_coef(conv_b_offset_meas);
          conv_b_gain_coef_reg          <= gain_coef(conv_b_gain_meas);
        end else begin
          cal_cnt_reg <= cal_cnt_reg + 10'd1;
        end
      end else if (conv_start && conv_channel == `MSB_CH_CAL) begin
        busy        <= 1'b1;
        cal_cnt_reg <= 10'd0;
      end
    end
  end

  // flag register, sampled every cycle
  always @(posedge core_clk) begin
    if (rst) begin
      flag_status_reg <= 16'h0000;
    end else if (clk_en) begin
      flag_status_reg                      <= 16'h0000;
      flag_status_reg[7:0]                 <= {1'b0, alarm_flags};
      flag_status_reg[`MSB_FLAG_OT_BIT]    <= over_temp_flag;
      flag_status_reg[`MSB_FLAG_REF_BIT]   <= internal_ref_sel;
      flag_status_reg[`MSB_FLAG_JTGRO_BIT] <= jtag_readonly_flag;
      flag_status_reg[`MSB_FLAG_JTGBL_BIT] <= jtag_blocked_flag;
    end
  end

  // read decode
  always @* begin
    rd_next = `MSB_UNDEF_VALUE;
    case (rcp_addr)
      `MSB_ADDR_SENS_A_OFS:   rd_next = conv_a_sensor_offset_coef_reg;
      `MSB_ADDR_CONV_A_OFS:   rd_next = conv_a_offset_coef_reg;
      `MSB_ADDR_CONV_A_GAIN:  rd_next = conv_a_gain_coef_reg;
      `MSB_ADDR_MIN_CORE:     rd_next = min_core_supply_reg;
      `MSB_ADDR_MIN_AUX:      rd_next = min_aux_supply_reg;
      `MSB_ADDR_MIN_BRAM:     rd_next = min_blockram_supply_reg;
      `MSB_ADDR_MAX_PS_CORE:  rd_next = max_ps_core_supply_reg;
      `MSB_ADDR_MAX_PS_AUX:   rd_next = max_ps_aux_supply_reg;
      `MSB_ADDR_MAX_PS_MEMIO: rd_next = max_ps_memio_supply_reg;
      `MSB_ADDR_MIN_PS_CORE:  rd_next = min_ps_core_supply_reg;
      `MSB_ADDR_MIN_PS_AUX:   rd_next = min_ps_aux_supply_reg;
      `MSB_ADDR_MIN_PS_MEMIO: rd_next = min_ps_memio_supply_reg;
      `MSB_ADDR_SENS_B_OFS:   rd_next = conv_b_sensor_offset_coef_reg;
      `MSB_ADDR_CONV_B_OFS:   rd_next = conv_b_offset_coef_reg;
      `MSB_ADDR_CONV_B_GAIN:  rd_next = conv_b_gain_coef_reg;
      `MSB_ADDR_FLAG:         rd_next = flag_status_reg;
      default:                rd_next = `MSB_UNDEF_VALUE;
    endcase
  end

  // port: one-cycle ready; writes acknowledged but store nothing
  always @(posedge core_clk) begin
    if (rst) begin
      rcp_do  <= 16'h0000;
      rcp_rdy <= 1'b0;
    end else if (clk_en) begin
      rcp_rdy <= rcp_en;
      if (rcp_en && !rcp_we)
        rcp_do <= rd_next;
      else if (rcp_en)
        rcp_do <= rcp_do;
    end
  end

endmodule // msb_status_bank

// ### msb_status_bank_props.sv
// msb_status_bank_props.sv: port assertions for the monitor status bank
// assumes clk_en is held high and a flag read is not issued within two cycles of reset
`timescale 1ns/1ps
module msb_props (
  input wire        core_clk,
  input wire        rst,
  input wire        rcp_en,
  input wire        rcp_we,
  input wire [6:0]  rcp_addr,
  input wire [15:0] rcp_do,
  input wire        rcp_rdy,
  input wire        conv_start,
  input wire [4:0]  conv_channel,
  input wire [6:0]  alarm_flags,
  input wire        over_temp_flag,
  input wire        internal_ref_sel,
  input wire        jtag_readonly_flag,
  input wire        jtag_blocked_flag,
  input wire        busy,
  input wire        cal_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  reg [7:0] busy_cnt;
  // counts busy cycles so the calibration length can be checked exactly
  always @(posedge core_clk) busy_cnt <= (rst || !busy) ? 8'h00 : busy_cnt + 8'h01;
  sequence s_cal_go; conv_start && conv_channel == 5'h08 && !busy; endsequence
  sequence s_cal_end; !busy && cal_done && busy_cnt == 8'd104; endsequence
  sequence s_flag_rd; rcp_rdy && $past(rcp_addr) == 7'h3F && !$past(rcp_we) && !$past(rst, 2); endsequence
  chk_rdy_follow: assert property (rcp_en |=> rcp_rdy) else $error("no ready after request");
  chk_rdy_cause: assert property (rcp_rdy |-> $past(rcp_en)) else $error("ready without request");
  chk_cal_start: assert property (s_cal_go |=> busy) else $error("busy not raised");
  chk_cal_length: assert property ($fell(busy) |-> s_cal_end) else $error("calibration length wrong");
  chk_done_pulse: assert property (cal_done |-> $fell(busy) ##1 !cal_done) else $error("done pulse wrong");
  chk_flag_alarm: assert property
    (s_flag_rd |-> (rcp_do[7:0] & 8'h77) == {1'b0, $past(alarm_flags, 2) & 7'h77}) else $error("alarm bits wrong");
  chk_flag_ot: assert property (s_flag_rd |-> rcp_do[3] == $past(over_temp_flag, 2)) else $error("ot bit wrong");
  chk_flag_ref: assert property
    (s_flag_rd |-> rcp_do[9] == $past(internal_ref_sel, 2)) else $error("ref bit wrong");
  chk_flag_jtag: assert property
    (s_flag_rd |-> rcp_do[11:10] == {$past(jtag_blocked_flag, 2), $past(jtag_readonly_flag, 2)}) else $error("jtag bits wrong");
  chk_gain_field: assert property
    (rcp_rdy && !$past(rcp_we) && ($past(rcp_addr) == 7'h0A || $past(rcp_addr) == 7'h32)
    |-> rcp_do[15:7] == 9'h000) else $error("gain upper bits set");
endmodule // msb_props
bind msb_status_bank msb_props u_props (.core_clk(core_clk), .rst(rst), .rcp_en(rcp_en), .rcp_we(rcp_we),
  .rcp_addr(rcp_addr), .rcp_do(rcp_do), .rcp_rdy(rcp_rdy), .conv_start(conv_start), .conv_channel(conv_channel),
  .alarm_flags(alarm_flags), .over_temp_flag(over_temp_flag), .internal_ref_sel(internal_ref_sel),
  .jtag_readonly_flag(jtag_readonly_flag), .jtag_blocked_flag(jtag_blocked_flag), .busy(busy), .cal_done(cal_done));

// ### msb_user.sv
// msb_user.sv: user logic on the reconfig port, one access per call
// assumes a one-cycle strobe and a registered ready one cycle later
`timescale 1ns/1ps
module msb_user (
  input  wire        core_clk,
  output reg         rcp_en,
  output reg         rcp_we,
  output reg  [6:0]  rcp_addr,
  output reg  [15:0] rcp_di,
  input  wire [15:0] rcp_do,
  input  wire        rcp_rdy
);
  initial begin
    rcp_en = 1'b0;
    rcp_we = 1'b0;
    rcp_addr = 7'h00;
    rcp_di = 16'h0000;
  end
  // released lines show the inverse of the last value
  task access(input logic we, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q, output logic ok);
    begin
      @(posedge core_clk); #1;
      rcp_en = 1'b1; rcp_we = we; rcp_addr = a; rcp_di = d;
      @(posedge core_clk); #1;
      rcp_en = 1'b0; rcp_we = ~we; rcp_addr = ~a; rcp_di = ~d;
      ok = rcp_rdy;
      q = rcp_do;
    end
  endtask
endmodule // msb_user

// ### test_monitor_status_calibration_bank.sv
// test_monitor_status_calibration_bank.sv: self-checking bench with a reference model
// assumes clk_en tied high; partner user logic drives the reconfig port
`timescale 1ns/1ps
module test_monitor_status_calibration_bank;
  reg          core_clk, rst, meas_valid, conv_start, over_temp_flag, internal_ref_sel;
  reg          jtag_readonly_flag, jtag_blocked_flag, ok;
  reg  [4:0]   meas_channel, conv_channel;
  reg  [15:0]  meas_data, q;
  reg  [11:0]  sa, ca, sb, cb;
  reg  [6:0]   ga, gb, alarm_flags;
  wire         rcp_en, rcp_we, rcp_rdy, busy, cal_done;
  wire [6:0]   rcp_addr;
  wire [15:0]  rcp_di, rcp_do;
  logic [15:0] mdl [0:127];
  bit          known [0:127];
  int          error_cnt, tests_run, n, k;
  int          ch [7] = '{1, 2, 6, 13, 14, 15, 3};
  int          mn_a [6] = '{'h25, 'h26, 'h27, 'h2C, 'h2D, 'h2E};
  int          mx_a [6] = '{0, 0, 0, 'h28, 'h29, 'h2A};
  int          cf_a [6] = '{'h08, 'h09, 'h0A, 'h30, 'h31, 'h32};
  msb_status_bank dut_u (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .rcp_en(rcp_en), .rcp_we(rcp_we),
    .rcp_addr(rcp_addr), .rcp_di(rcp_di), .rcp_do(rcp_do), .rcp_rdy(rcp_rdy), .meas_valid(meas_valid),
    .meas_channel(meas_channel), .meas_data(meas_data), .conv_start(conv_start), .conv_channel(conv_channel),
    .sens_a_offset_meas(sa), .conv_a_offset_meas(ca), .conv_a_gain_meas(ga), .sens_b_offset_meas(sb),
    .conv_b_offset_meas(cb), .conv_b_gain_meas(gb), .alarm_flags(alarm_flags), .over_temp_flag(over_temp_flag),
    .internal_ref_sel(internal_ref_sel), .jtag_readonly_flag(jtag_readonly_flag),
    .jtag_blocked_flag(jtag_blocked_flag), .busy(busy), .cal_done(cal_done));
  msb_user u_user (.core_clk(core_clk), .rcp_en(rcp_en), .rcp_we(rcp_we), .rcp_addr(rcp_addr), .rcp_di(rcp_di),
    .rcp_do(rcp_do), .rcp_rdy(rcp_rdy));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    begin
      tests_run++;
      if (g !== e) begin
        error_cnt++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  function logic [15:0] flag_exp;
    flag_exp = {4'h0, jtag_blocked_flag, jtag_readonly_flag, internal_ref_sel, 2'b00, alarm_flags[6:4],
                over_temp_flag, alarm_flags[2:0]};
  endfunction
  task rd(input logic [6:0] a, input logic we);
    begin
      u_user.access(we, a, 16'($urandom), q, ok);
      chk("ready", 16'h0001, {15'h0000, ok});
      // undefined locations are ignored by the reader
      if (!we && a == 7'h3F) chk($sformatf("addr %h", a), flag_exp(), q);
      else if (!we && known[a]) chk($sformatf("addr %h", a), mdl[a], q);
    end
  endtask
  task read_all;
    for (int i = 0; i < 128; i++) rd(7'(i), 1'b0);
  endtask
  task do_reset;
    begin
      rst = 1'b1;
      repeat (20) @(posedge core_clk);
      #1 rst = 1'b0;
      foreach (mdl[i]) begin mdl[i] = 16'h0000; known[i] = 1'b0; end
      foreach (mn_a[i]) begin mdl[mn_a[i]] = 16'hFFFF; known[mn_a[i]] = 1'b1; known[cf_a[i]] = 1'b1; end
      foreach (mx_a[i]) known[mx_a[i]] = (mx_a[i] != 0);
    end
  endtask
  initial begin
    #(8 * 30000);
    error_cnt++;
    summarize;
  end
  initial begin
    rst = 1'b1; meas_valid = 1'b0; conv_start = 1'b0; meas_channel = 5'h00; conv_channel = 5'h00;
    meas_data = 16'h0000; {sa, ca, sb, cb, ga, gb} = 62'h0;
    {alarm_flags, over_temp_flag, internal_ref_sel, jtag_readonly_flag, jtag_blocked_flag} = 11'h000;
    error_cnt = 0; tests_run = 0;
    n = $urandom(32'h4760FC71);
    do_reset; read_all; $display("test reset values done");
    repeat (80) begin
      n = $urandom_range(6, 0);
      @(posedge core_clk); #1;
      meas_valid = 1'b1; meas_channel = 5'(ch[n]); meas_data = 16'($urandom);
      if (n < 6 && meas_data < mdl[mn_a[n]]) mdl[mn_a[n]] = meas_data;
      if (n < 6 && mx_a[n] != 0 && meas_data > mdl[mx_a[n]]) mdl[mx_a[n]] = meas_data;
    end
    @(posedge core_clk); #1 meas_valid = 1'b0;
    read_all; $display("test extremes done");
    repeat (12) begin
      @(posedge core_clk); #1;
      {alarm_flags, over_temp_flag, internal_ref_sel, jtag_readonly_flag, jtag_blocked_flag} = 11'($urandom);
      rd(7'h3F, 1'b0);
    end
    $display("test flags done");
    {sa, ca, sb, cb, ga, gb} = 62'({$urandom, $urandom});
    @(posedge core_clk); #1 conv_start = 1'b1; conv_channel = 5'h08;
    @(posedge core_clk); #1 conv_start = 1'b0;
    n = 0;
    for (k = 0; k < 300 && cal_done !== 1'b1; k++) begin
      if (busy === 1'b1) n++;
      conv_start = (k == 50);
      @(posedge core_clk); #1;
    end
    chk("busy cycles", 16'd104, 16'(n));
    mdl['h08] = {~sa + 12'h001, 4'h0}; mdl['h09] = {~ca + 12'h001, 4'h0};
    mdl['h30] = {~sb + 12'h001, 4'h0}; mdl['h31] = {~cb + 12'h001, 4'h0};
    mdl['h0A] = {9'h000, ~ga[6], ga[5:0]}; mdl['h32] = {9'h000, ~gb[6], gb[5:0]};
    foreach (cf_a[i]) rd(7'(cf_a[i]), 1'b1);
    read_all; $display("test calibration done");
    do_reset; read_all; $display("test second reset done");
    summarize;
  end
endmodule // test_monitor_status_calibration_bank
